// [core/byte_lane_decode.sv]
// byte lane decode from address, size and port width
// combinational, same clock domain as its user
`timescale 1ns/1ps
`default_nettype none
module byte_lane_decode
  import memctl_pkg::*;
(
  input wire logic [2:0] addr_lo,
  input wire logic [1:0] size,
  input wire logic [1:0] port_w,
  output logic [NUM_LANES-1:0] lanes
);
  logic [3:0] nbytes;
  logic [3:0] pbytes;
  logic [2:0] offs;
  logic [15:0] mask;

  // active-high lane enables; the caller inverts for the pins
  always_comb begin
    nbytes = 4'h1 << size;
    pbytes = 4'h1 << port_w;
    if (nbytes > pbytes) begin
      nbytes = pbytes;
    end
    offs = addr_lo & 3'(pbytes - 4'h1);
    mask = 16'((16'h1 << nbytes) - 16'h1) << offs;
    lanes = mask[NUM_LANES-1:0];
  end
endmodule : byte_lane_decode
`default_nettype wire

// [core/external_memory_ctrl_pins.sv]
// pin sequencer for the three memory machines
// requests arrive from internal bus logic on clk_sys; ack and wait are pins
`timescale 1ns/1ps
`default_nettype none
module external_memory_ctrl_pins
  import memctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [1:0] req_machine,
  input wire logic [2:0] req_cs,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [1:0] req_size,
  input wire logic [1:0] req_port_w,
  input wire logic [1:0] req_beats,
  input wire logic req_parity_en,
  input wire logic [NUM_GPL*PAT_LEN-1:0] prog_pattern,
  input wire logic ext_master_mode,
  input wire logic [CFG_W-1:0] buffer_ctrl_config,
  input wire logic gcm_transfer_ack_n,
  input wire logic prog_machine_wait_in,
  output logic req_ready,
  output logic done_pulse,
  output logic [NUM_CS-1:0] cs_n,
  output logic [NUM_LANES-1:0] gcm_byte_write_en_n,
  output logic read_output_en_n,
  output logic [NUM_LANES-1:0] prog_machine_byte_sel_n,
  output logic prog_machine_line_zero,
  output logic prog_machine_line_one,
  output logic prog_machine_line_two,
  output logic prog_machine_line_three,
  output logic prog_machine_line_four,
  output logic prog_machine_line_five,
  output logic [NUM_LANES-1:0] sdram_byte_mask,
  output logic sdram_row_cmd_bit,
  output logic sdram_write_en_n,
  output logic sdram_row_strobe_n,
  output logic sdram_col_strobe_n,
  output logic addr_latch_en,
  output logic sdram_addr_mux_sel,
  output logic data_buffer_ctrl_zero,
  output logic data_buffer_ctrl_one,
  output logic [1:0] burst_addr_out,
  output logic parity_chip_byte_sel_n
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic ack_meta_q, ack_n_q;
  logic wait_meta_q, wait_q;

  // pulled-up ack idles high, so reset to the inactive level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_meta_q <= 1'b1;
      ack_n_q <= 1'b1;
      wait_meta_q <= 1'b0;
      wait_q <= 1'b0;
    end else begin
      ack_meta_q <= gcm_transfer_ack_n;
      ack_n_q <= ack_meta_q;
      wait_meta_q <= prog_machine_wait_in;
      wait_q <= wait_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request capture
  mstate_t state_q;
  logic [2:0] cs_q;
  logic wr_q;
  logic [31:0] addr_q;
  logic [1:0] size_q, port_q, beats_q, beat_q;
  logic par_q;
  logic [NUM_LANES-1:0] lanes;
  logic take;
  logic [1:0] step_q;

  assign take = (state_q == ST_IDLE) && req_valid;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_q <= 3'h0;
      wr_q <= 1'b0;
      addr_q <= 32'h0;
      size_q <= SIZE_BYTE;
      port_q <= PORT_8;
      beats_q <= 2'h0;
      par_q <= 1'b0;
    end else if (take) begin
      cs_q <= req_cs;
      wr_q <= req_write;
      addr_q <= req_addr;
      size_q <= req_size;
      port_q <= req_port_w;
      beats_q <= req_beats;
      par_q <= req_parity_en;
    end
  end

  byte_lane_decode byte_lane_decode_inst (
    .addr_lo(addr_q[2:0]),
    .size(size_q),
    .port_w(port_q),
    .lanes(lanes)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  logic beat_end;
  logic last_beat;
  assign last_beat = (beat_q == beats_q);

  always_comb begin
    case (state_q)
      ST_GCM: beat_end = !ack_n_q;
      ST_PRG: beat_end = !wait_q && (step_q == 2'(PAT_LEN - 1));
      ST_SDR_RW: beat_end = 1'b1;
      default: beat_end = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: if (req_valid) begin
          case (req_machine)
            MACH_GCM: state_q <= ST_GCM;
            MACH_PRG: state_q <= ST_PRG;
            default: state_q <= ST_SDR_ACT;
          endcase
        end
        ST_SDR_ACT: state_q <= ST_SDR_RW;
        ST_GCM, ST_PRG, ST_SDR_RW: if (beat_end && last_beat) begin
          state_q <= ST_DONE;
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // programmed pattern step holds while wait is high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      step_q <= 2'h0;
    end else if (state_q != ST_PRG) begin
      step_q <= 2'h0;
    end else if (!wait_q) begin
      step_q <= step_q + 2'h1;
    end
  end

  // burst beat counter drives the burst address bits
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      beat_q <= BURST_ZERO;
    end else if (take) begin
      beat_q <= BURST_ZERO;
    end else if (beat_end && !last_beat) begin
      beat_q <= beat_q + BEAT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin registers
  logic gcm_on, prg_on, sdr_on, act_on;
  assign gcm_on = (state_q == ST_GCM);
  assign prg_on = (state_q == ST_PRG);
  assign sdr_on = (state_q == ST_SDR_ACT) || (state_q == ST_SDR_RW);
  assign act_on = gcm_on || prg_on || sdr_on;

  logic [NUM_GPL-1:0] gpl;
  genvar g;
  generate
    for (g = 0; g < NUM_GPL; g++) begin : g_gpl
      assign gpl[g] = prg_on ? prog_pattern[g*PAT_LEN + int'(step_q)] : GPL_IDLE[g];
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_ready <= 1'b0;
      done_pulse <= 1'b0;
      cs_n <= CS_IDLE;
      gcm_byte_write_en_n <= LANES_IDLE;
      read_output_en_n <= 1'b1;
      prog_machine_byte_sel_n <= LANES_IDLE;
      {prog_machine_line_five, prog_machine_line_four, prog_machine_line_three,
       prog_machine_line_two, prog_machine_line_one, prog_machine_line_zero} <= GPL_IDLE;
      sdram_byte_mask <= LANES_IDLE;
      sdram_row_cmd_bit <= 1'b0;
      sdram_write_en_n <= 1'b1;
      sdram_row_strobe_n <= 1'b1;
      sdram_col_strobe_n <= 1'b1;
      addr_latch_en <= 1'b0;
      sdram_addr_mux_sel <= 1'b0;
      data_buffer_ctrl_zero <= 1'b1;
      data_buffer_ctrl_one <= 1'b1;
      burst_addr_out <= BURST_ZERO;
      parity_chip_byte_sel_n <= 1'b1;
    end else begin
      req_ready <= (state_q == ST_IDLE) && !req_valid;
      done_pulse <= act_on && beat_end && last_beat;
      cs_n <= CS_IDLE;
      if (act_on) begin
        cs_n[cs_q] <= 1'b0;
      end
      gcm_byte_write_en_n <= (gcm_on && wr_q) ? ~lanes : LANES_IDLE;
      read_output_en_n <= !(gcm_on && !wr_q);
      prog_machine_byte_sel_n <= prg_on ? ~lanes : LANES_IDLE;
      {prog_machine_line_five, prog_machine_line_four, prog_machine_line_three,
       prog_machine_line_two, prog_machine_line_one, prog_machine_line_zero} <= gpl;
      sdram_byte_mask <= (state_q == ST_SDR_RW) ? ~lanes : LANES_IDLE;
      // row phase shows address bit 10, column phase shows the command bit
      sdram_row_cmd_bit <= (state_q == ST_SDR_ACT) ? addr_q[ROW_CMD_ADDR_BIT] :
                           (state_q == ST_SDR_RW) ? SDR_A10_CMD : 1'b0;
      sdram_row_strobe_n <= !(state_q == ST_SDR_ACT);
      sdram_col_strobe_n <= !(state_q == ST_SDR_RW);
      sdram_write_en_n <= !((state_q == ST_SDR_RW) && wr_q);
      addr_latch_en <= ext_master_mode && take;
      sdram_addr_mux_sel <= ext_master_mode && (state_q == ST_SDR_RW);
      // config picks enable+direction or separate read/write strobes
      if (buffer_ctrl_config == BCFG_RD_WR) begin
        data_buffer_ctrl_zero <= !(act_on && wr_q);
        data_buffer_ctrl_one <= !(act_on && !wr_q);
      end else begin
        data_buffer_ctrl_zero <= !act_on;
        data_buffer_ctrl_one <= !wr_q;
      end
      burst_addr_out <= act_on ? (addr_q[BURST_ADDR_LSB +: 2] + beat_q) : BURST_ZERO;
      parity_chip_byte_sel_n <= !(act_on && par_q);
    end
  end

endmodule : external_memory_ctrl_pins
`default_nettype wire

// [core/memctl_pkg.sv]
// constants shared by the external memory pin controller
// assumes one 100 MHz system clock and an internal request port driven by bus logic
//
// What this block does
// - eight active-low chip selects, one per device
// - general machine drives eight byte write enables
// - general machine output enable during reads
// - external transfer acknowledge ends general transaction
// - wait input high stalls programmed machine
// - programmed byte selects from address, size, width
// - six programmed general-purpose lines from pattern
// - sdram machine drives eight byte masks
// - a10 carries row bit, then command bit
// - sdram write, row and column strobes
// - address latch enable in external master mode
// - sdram address mux select in external master
// - two buffer controls shaped by config field
// - burst address bits advance each beat
// - parity chip byte select when parity separate
`default_nettype none
package memctl_pkg;

  localparam int NUM_CS = 8;
  localparam int NUM_LANES = 8;
  localparam int NUM_GPL = 6;
  localparam int PAT_LEN = 4;
  localparam int CFG_W = 2;

  localparam logic [NUM_CS-1:0] CS_IDLE = 8'hFF;
  localparam logic [NUM_LANES-1:0] LANES_IDLE = 8'hFF;
  localparam logic [NUM_GPL-1:0] GPL_IDLE = 6'h3F;
  localparam logic [1:0] BURST_ZERO = 2'h0;
  localparam logic [1:0] BEAT_ONE = 2'h1;

  // address bit shown on a10 in the row phase, low bit of the burst address field
  localparam int ROW_CMD_ADDR_BIT = 10;
  localparam int BURST_ADDR_LSB = 3;

  // machine select
  localparam logic [1:0] MACH_GCM = 2'h0;
  localparam logic [1:0] MACH_PRG = 2'h1;
  localparam logic [1:0] MACH_SDR = 2'h2;

  // transfer size codes (bytes = 1 << size)
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_DWORD = 2'h3;

  // port width codes
  localparam logic [1:0] PORT_8 = 2'h0;
  localparam logic [1:0] PORT_16 = 2'h1;
  localparam logic [1:0] PORT_32 = 2'h2;
  localparam logic [1:0] PORT_64 = 2'h3;

  // buffer control configurations
  localparam logic [CFG_W-1:0] BCFG_DIR_EN = 2'h0;
  localparam logic [CFG_W-1:0] BCFG_RD_WR = 2'h1;

  // sdram command bit carried on a10 during column phase (auto precharge)
  localparam logic SDR_A10_CMD = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_GCM, ST_PRG, ST_SDR_ACT, ST_SDR_RW, ST_DONE
  } mstate_t;

endpackage : memctl_pkg
`default_nettype wire

// [dv/external_memory_ctrl_pins_properties.sv]
// assertions on the strobes of the pin controller
// bound into every instance of the controller
`timescale 1ns/1ps
`default_nettype none
module memctl_pin_checker
  import memctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_ready,
  input wire logic done_pulse,
  input wire logic [NUM_CS-1:0] cs_n,
  input wire logic [NUM_LANES-1:0] gcm_byte_write_en_n,
  input wire logic read_output_en_n,
  input wire logic [NUM_LANES-1:0] prog_machine_byte_sel_n,
  input wire logic sdram_row_cmd_bit,
  input wire logic sdram_row_strobe_n,
  input wire logic sdram_col_strobe_n,
  input wire logic gcm_transfer_ack_n,
  input wire logic addr_latch_en,
  input wire logic ext_master_mode,
  input wire logic parity_chip_byte_sel_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  cs_single_a: assert property ($countones(~cs_n) <= 1)
    else $error("two chip selects low");
  idle_quiet_a: assert property (req_ready |-> cs_n == CS_IDLE && read_output_en_n
    && gcm_byte_write_en_n == LANES_IDLE && prog_machine_byte_sel_n == LANES_IDLE)
    else $error("strobe active while idle");
  read_no_write_a: assert property (!read_output_en_n |-> gcm_byte_write_en_n == LANES_IDLE)
    else $error("read enable with write lanes");
  write_with_cs_a: assert property (gcm_byte_write_en_n != LANES_IDLE |-> cs_n != CS_IDLE)
    else $error("write lane without chip select");
  row_then_col_a: assert property ($fell(sdram_row_strobe_n) |=> $fell(sdram_col_strobe_n))
    else $error("column strobe not after row strobe");
  col_cmd_bit_a: assert property (!sdram_col_strobe_n |-> sdram_row_cmd_bit == SDR_A10_CMD)
    else $error("a10 not command bit in column phase");
  no_ack_done_a: assert property ((!read_output_en_n && gcm_transfer_ack_n)[*6] |-> !done_pulse)
    else $error("read ended without acknowledge");
  ale_mode_a: assert property (addr_latch_en |-> ext_master_mode ##1 !addr_latch_en)
    else $error("latch enable wrong");
  parity_cs_a: assert property (!parity_chip_byte_sel_n |-> cs_n != CS_IDLE)
    else $error("parity select outside access");
  cover property (!read_output_en_n ##[1:40] done_pulse);
  cover property (!sdram_col_strobe_n);
  cover property (prog_machine_byte_sel_n != LANES_IDLE);
endmodule : memctl_pin_checker
bind external_memory_ctrl_pins memctl_pin_checker memctl_pin_checker_inst (.*);
`default_nettype wire

// [dv/memctl_dev_model.sv]
// behavioural model of the memory and peripherals on the controller's pins
// same clock as the controller; delays come from the bench
`timescale 1ns/1ps
`default_nettype none
module memctl_dev_model
  import memctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [NUM_CS-1:0] cs_n,
  input wire logic [NUM_LANES-1:0] gcm_byte_write_en_n,
  input wire logic read_output_en_n,
  input wire logic [NUM_LANES-1:0] prog_machine_byte_sel_n,
  input wire logic [1:0] ack_dly,
  input wire logic [1:0] wait_len,
  output logic gcm_transfer_ack_n,
  output logic prog_machine_wait_in
);
  logic [3:0] acnt_q;
  logic [3:0] wcnt_q;
  logic gcm_on;
  logic prg_on;
  assign gcm_on = (cs_n != CS_IDLE) && (!read_output_en_n || gcm_byte_write_en_n != LANES_IDLE);
  assign prg_on = prog_machine_byte_sel_n != LANES_IDLE;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst || !gcm_on || acnt_q == {2'h0, ack_dly} + 4'h6) begin
      acnt_q <= 4'h0;
    end else begin
      acnt_q <= acnt_q + 4'h1;
    end
  end
  // low three cycles so the two-stage sync sees it; pulled up otherwise
  assign gcm_transfer_ack_n = !(acnt_q > {2'h0, ack_dly} && acnt_q <= {2'h0, ack_dly} + 4'h3);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst || !prg_on) begin
      wcnt_q <= 4'h0;
    end else begin
      wcnt_q <= wcnt_q + 4'h1;
    end
  end
  assign prog_machine_wait_in = wcnt_q != 4'h0 && wcnt_q <= {2'h0, wait_len};
endmodule : memctl_dev_model
`default_nettype wire

// [dv/test_external_memory_ctrl_pins.sv]
// random requests on all machines; the monitor checks selects, lanes, sdram and side pins
// assumes the device model answers ack and wait
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module test_external_memory_ctrl_pins
  import memctl_pkg::*;
;
  logic clk_sys = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic req_parity_en = 1'b0, ext_master_mode = 1'b0;
  logic [1:0] req_machine = 2'h0, req_size = 2'h0, req_port_w = 2'h0, req_beats = 2'h0;
  logic [1:0] buffer_ctrl_config = 2'h0, ack_dly = 2'h0, wait_len = 2'h0;
  logic [2:0] req_cs = 3'h0;
  logic [31:0] req_addr = 32'h0, seed = 32'h44;
  logic [NUM_GPL*PAT_LEN-1:0] prog_pattern = '0;
  logic gcm_transfer_ack_n, prog_machine_wait_in, req_ready, done_pulse, read_output_en_n;
  logic sdram_row_cmd_bit, sdram_row_strobe_n, sdram_col_strobe_n;
  logic addr_latch_en, parity_chip_byte_sel_n;
  logic sdram_write_en_n, sdram_addr_mux_sel, data_buffer_ctrl_zero, data_buffer_ctrl_one;
  logic prog_machine_line_zero, prog_machine_line_one, prog_machine_line_two;
  logic prog_machine_line_three, prog_machine_line_four, prog_machine_line_five;
  logic [1:0] burst_addr_out, bufctl;
  logic [5:0] gpl_pins;
  logic [7:0] cs_n, gcm_byte_write_en_n, prog_machine_byte_sel_n, sdram_byte_mask;
  logic [7:0] acc_cs = 8'hFF, acc_ln = 8'hFF;
  logic acc_oe = 1'b1;
  // active-low view: {mux select, latch enable, parity select, sdram write, row strobe}
  logic [4:0] acc_sd = 5'h1F;
  logic [31:0] q[$];
  logic [31:0] e;
  int error_cnt = 0, num_checks = 0;
  always #5 clk_sys = ~clk_sys;
  external_memory_ctrl_pins external_memory_ctrl_pins_inst (.*);
  assign gpl_pins = {prog_machine_line_five, prog_machine_line_four, prog_machine_line_three,
    prog_machine_line_two, prog_machine_line_one, prog_machine_line_zero};
  assign bufctl = {data_buffer_ctrl_zero, data_buffer_ctrl_one};
  memctl_dev_model memctl_dev_model_inst (.*);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // lane count is the smaller of size and port, offset folded into the port
  function automatic logic [7:0] lanes(logic [2:0] a, logic [1:0] sz, logic [1:0] pw);
    logic [7:0] m;
    m = (8'h01 << (8'h01 << ((sz < pw) ? sz : pw))) - 8'h01;
    return ~(m << (a & ((3'h1 << pw) - 3'h1)));
  endfunction : lanes
  task automatic go();
    logic [31:0] r;
    logic [31:0] a;
    int n;
    logic [NUM_GPL*PAT_LEN-1:0] p;
    r = rnd();
    a = rnd() & ~((32'h1 << r[7:6]) - 32'h1);
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 100) begin
      error_cnt++;
      end_of_test();
    end
    p = 24'(rnd());
    // field order matches the expectation below: machine in the low bits
    {req_port_w, req_size, req_write, req_cs, req_machine} <= r[9:0];
    {req_beats, req_parity_en, ext_master_mode, buffer_ctrl_config} <= r[15:10];
    {ack_dly, wait_len} <= r[19:16];
    req_addr <= a;
    prog_pattern <= p;
    req_valid <= 1'b1;
    q.push_back({~(8'h01 << r[4:2]), (r[1:0] == MACH_GCM && !r[5]) ? 8'hFF :
      lanes(a[2:0], r[7:6], r[9:8]), !(r[1:0] == MACH_GCM && !r[5]),
      !(r[12] && r[1]), !r[12], !r[13], !(r[1] && r[5]), !r[1], 2'(a[4:3] + r[15:14]),
      (r[1:0] == MACH_PRG) ? {p[23], p[19], p[15], p[11], p[7], p[3]} : GPL_IDLE,
      (r[11:10] == BCFG_RD_WR) ? {!r[5], r[5]} : {1'b0, !r[5]}});
    @(posedge clk_sys);
    req_valid <= 1'b0;
    n = 0;
    while (done_pulse !== 1'b1 && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 300) begin
      error_cnt++;
      end_of_test();
    end
  endtask : go
  always @(posedge clk_sys) begin
    if (!rst) begin
      acc_cs = acc_cs & cs_n;
      acc_oe = acc_oe & read_output_en_n;
      acc_ln = acc_ln & gcm_byte_write_en_n & prog_machine_byte_sel_n
        & (sdram_col_strobe_n ? 8'hFF : sdram_byte_mask);
      acc_sd = acc_sd & {~sdram_addr_mux_sel, ~addr_latch_en, parity_chip_byte_sel_n,
        sdram_write_en_n, sdram_row_strobe_n};
      if (done_pulse === 1'b1) begin
        e = (q.size() > 0) ? q.pop_front() : 32'h0;
        `CHK(acc_cs, e[31:24])
        `CHK(acc_ln, e[23:16])
        `CHK(acc_oe, e[15])
        `CHK(acc_sd, e[14:10])
        `CHK(burst_addr_out, e[9:8])
        `CHK(gpl_pins, e[7:2])
        `CHK(bufctl, e[1:0])
        {acc_cs, acc_ln, acc_oe, acc_sd} = 22'h3FFFFF;
      end
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (80) go();
    end_of_test();
  end
endmodule : test_external_memory_ctrl_pins
`default_nettype wire
